// ### shared/gupc_pkg.sv
// package for the upper pin configuration block: offsets, field layout,
// reset values and function-select codes.
// assumes a 32-bit apb register bus with byte addresses.
package gupc_pkg;
    localparam int          NPIN         = 5;
    localparam int          ADDR_W       = 12;
    localparam int          STRIDE       = 3;
    localparam int          SEL_W        = 3;
    // register byte offsets
    localparam logic [11:0] OFS_SELECT   = 12'h008;
    localparam logic [11:0] OFS_CFG      = 12'h00C;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
    localparam logic [11:0] OFS_IRQ_CLR  = 12'h024;
    localparam logic [11:0] OFS_IRQ_EN   = 12'h028;
    // field positions for the lowest pin (pin 5); higher pins add STRIDE
    localparam int          FLAG_LSB     = 16;
    localparam int          DRIVE_LSB    = 17;
    localparam int          LEVEL_LSB    = 18;
    localparam int          SEL_LSB      = 16;
    localparam int          RESERVED_BIT_HI      = 31;
    localparam int          RESERVED_BIT_LO      = 15;
    // reset values
    localparam logic [4:0]  RST_PINS     = 5'h00;
    localparam logic [14:0] RST_SEL      = 15'h0000;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    // function select codes
    localparam logic [2:0]  FSEL_INPUT   = 3'h0;
    localparam logic [2:0]  FSEL_OUTPUT  = 3'h7;
endpackage

// ### shared/gupc_reg_if.sv
// register access bundle between the apb slave and the register file.
// assumes one clock; the slave drives strobes, the register file answers.
`timescale 1ns/1ps
`default_nettype none
interface gupc_reg_if;
    logic        wr_stb;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;
    modport slave (output wr_stb, output addr, output wdata, input rdata, input hit);
    modport regs  (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ### rtl/gupc_pin_sync.sv
// pin level synchroniser and change detector for the five upper pins.
// assumes pins may change at any time relative to pclk.
`timescale 1ns/1ps
`default_nettype none
module gupc_pin_sync (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [4:0] pin_in,
    output logic      [4:0] level,
    output logic      [4:0] change
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] level;
        logic [4:0] prev;
    } gupc_sync_s;

    gupc_sync_s s;
    gupc_sync_s next_s;

    always_comb begin
        next_s       = s;
        next_s.meta  = pin_in;
        // meta is read by the second stage only
        next_s.level = s.meta; // [RULE8]
        next_s.prev  = s.level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level  = s.level;
    // one-cycle pulse when the synchronised sample differs from the last
    assign change = s.level ^ s.prev;

    property p_sync_latency;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn, 3) |-> level == $past(pin_in, 2);
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("level not two cycles behind pin"); // [RULE8]

    property p_change_cause;
        @(posedge pclk) disable iff (!presetn)
        change[0] |-> level[0] != $past(level[0]);
    endproperty
    a_change_cause: assert property (p_change_cause) else $error("change without level shift"); // [RULE8]
endmodule
`default_nettype wire

// ### rtl/gupc_apb_slave.sv
// apb slave front end: zero-wait access, registered read data.
// assumes the register file answers rdata and hit combinationally.
`timescale 1ns/1ps
`default_nettype none
module gupc_apb_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    gupc_reg_if.slave        bus
);
    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } gupc_apb_s;

    gupc_apb_s s;
    gupc_apb_s next_s;

    always_comb begin
        next_s = s;
        // sample at setup so prdata comes straight from a flop
        if (psel && !penable) begin
            next_s.rdata = pwrite ? gupc_pkg::RST_WORD : bus.rdata;
            next_s.err   = !bus.hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.addr   = paddr;
    assign bus.wdata  = pwdata;
    assign bus.wr_stb = psel && penable && pwrite && !s.err;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && s.err;
    assign prdata     = s.rdata;
endmodule
`default_nettype wire

// ### rtl/gupc_top.sv
// upper pin configuration block: pins 5 to 9, level, drive, change flag,
// function select and a maskable change interrupt, over apb.
// assumes pins sampled into pclk here; index 0 of every vector is pin 5.
//
// Functional notes
// [RULE1] Bits 31 and 15 of the configuration word ignore writes and read zero.
// [RULE2] Bits 30, 27, 24, 21, 18 read the present level of pins 9 to 5, zero after reset.
// [RULE3] A pin selected as plain output drives its stored drive bit (29, 26, 23, 20, 17), zero after reset.
// [RULE4] A level change on a pin sets its change flag (28, 25, 22, 19, 16), zero after reset.
// [RULE5] A set change flag also sets the pin's system interrupt bit, only when that source is enabled.
// [RULE6] Writing 1 to a change flag clears it until the next level change on its pin.
// [RULE7] Select code 000 makes a pin an input, 111 a plain output, other codes route internal functions.
// [RULE8] Pins are synchronised, changes found by comparing samples, and writing 0 to a flag does nothing.
`timescale 1ns/1ps
`default_nettype none
module gupc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  pin_in,
    output logic      [4:0]  pin_out,
    output logic      [4:0]  pin_oe,
    input  wire logic [4:0]  func_out,
    input  wire logic [4:0]  func_oe,
    output logic      [4:0]  system_pin_change_irq,
    output logic             irq
);
    typedef struct packed {
        logic [4:0]  drive;
        logic [4:0]  flag;
        logic [14:0] sel;
        logic [4:0]  irq_stat;
        logic [4:0]  irq_en;
        logic [4:0]  pin_out;
        logic [4:0]  pin_oe;
    } gupc_top_s;

    gupc_top_s   s;
    gupc_top_s   next_s;
    logic [4:0]  level;
    logic [4:0]  change;
    logic        sel_wr;
    logic        cfg_wr;
    logic        clr_wr;
    logic        en_wr;

    gupc_reg_if bus ();

    function automatic int flag_pos(input int k);
        flag_pos = gupc_pkg::FLAG_LSB + k * gupc_pkg::STRIDE;
    endfunction

    function automatic int drive_pos(input int k);
        drive_pos = gupc_pkg::DRIVE_LSB + k * gupc_pkg::STRIDE;
    endfunction

    function automatic int level_pos(input int k);
        level_pos = gupc_pkg::LEVEL_LSB + k * gupc_pkg::STRIDE;
    endfunction

    gupc_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.slave)
    );

    gupc_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pin_in),
        .level   (level),
        .change  (change)
    );

    assign sel_wr = bus.wr_stb && (bus.addr == gupc_pkg::OFS_SELECT);
    assign cfg_wr = bus.wr_stb && (bus.addr == gupc_pkg::OFS_CFG);
    assign clr_wr = bus.wr_stb && (bus.addr == gupc_pkg::OFS_IRQ_CLR);
    assign en_wr  = bus.wr_stb && (bus.addr == gupc_pkg::OFS_IRQ_EN);

    // address decode: status is read-only, the clear register write-only
    always_comb begin
        bus.hit = (bus.addr == gupc_pkg::OFS_SELECT)
               || (bus.addr == gupc_pkg::OFS_CFG)
               || (bus.addr == gupc_pkg::OFS_IRQ_STAT)
               || (bus.addr == gupc_pkg::OFS_IRQ_CLR)
               || (bus.addr == gupc_pkg::OFS_IRQ_EN);
    end

    // read mux; unlisted bits, including 31 and 15, stay zero
    always_comb begin
        bus.rdata = gupc_pkg::RST_WORD; // [RULE1]
        case (bus.addr)
            gupc_pkg::OFS_SELECT: begin
                bus.rdata[gupc_pkg::SEL_LSB +: 15] = s.sel;
            end
            gupc_pkg::OFS_CFG: begin
                for (int k = 0; k < gupc_pkg::NPIN; k++) begin
                    bus.rdata[level_pos(k)] = level[k]; // [RULE2]
                    bus.rdata[drive_pos(k)] = s.drive[k];
                    bus.rdata[flag_pos(k)]  = s.flag[k];
                end
            end
            gupc_pkg::OFS_IRQ_STAT: begin
                bus.rdata[4:0] = s.irq_stat;
            end
            gupc_pkg::OFS_IRQ_EN: begin
                bus.rdata[4:0] = s.irq_en;
            end
            default: begin
                bus.rdata = gupc_pkg::RST_WORD;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        if (en_wr) begin
            next_s.irq_en = bus.wdata[4:0];
        end
        if (sel_wr) begin
            next_s.sel = bus.wdata[gupc_pkg::SEL_LSB +: 15];
        end
        for (int k = 0; k < gupc_pkg::NPIN; k++) begin
            // level bits are not stored, so writes to them are lost
            if (cfg_wr) begin
                next_s.drive[k] = bus.wdata[drive_pos(k)]; // [RULE3]
            end
            // writing 0 leaves the flag alone
            if (cfg_wr && bus.wdata[flag_pos(k)]) begin
                next_s.flag[k] = 1'b0; // [RULE6] [RULE8]
            end
            // a change in the clearing cycle still sets the flag
            if (change[k]) begin
                next_s.flag[k] = 1'b1; // [RULE4]
            end
            if (clr_wr && bus.wdata[k]) begin
                next_s.irq_stat[k] = 1'b0;
            end
            if (change[k] && s.irq_en[k]) begin
                next_s.irq_stat[k] = 1'b1; // [RULE5]
            end
            case (next_s.sel[k*gupc_pkg::SEL_W +: gupc_pkg::SEL_W])
                gupc_pkg::FSEL_INPUT: begin
                    next_s.pin_out[k] = 1'b0; // [RULE7]
                    next_s.pin_oe[k]  = 1'b0;
                end
                gupc_pkg::FSEL_OUTPUT: begin
                    next_s.pin_out[k] = next_s.drive[k]; // [RULE3] [RULE7]
                    next_s.pin_oe[k]  = 1'b1;
                end
                default: begin
                    // internal function owns the pin
                    next_s.pin_out[k] = func_out[k]; // [RULE7]
                    next_s.pin_oe[k]  = func_oe[k];
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.drive    <= gupc_pkg::RST_PINS;
            s.flag     <= gupc_pkg::RST_PINS;
            s.sel      <= gupc_pkg::RST_SEL;
            s.irq_stat <= gupc_pkg::RST_PINS;
            s.irq_en   <= gupc_pkg::RST_PINS;
            s.pin_out  <= gupc_pkg::RST_PINS;
            s.pin_oe   <= gupc_pkg::RST_PINS;
        end else begin
            s <= next_s;
        end
    end

    assign pin_out               = s.pin_out;
    assign pin_oe                = s.pin_oe;
    assign system_pin_change_irq = s.irq_stat;
    assign irq                   = |(s.irq_stat & s.irq_en);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reserved_bit_zero;
        (psel && !penable && !pwrite && paddr == gupc_pkg::OFS_CFG)
            |=> (prdata[31] == 1'b0) && (prdata[15] == 1'b0);
    endproperty
    a_reserved_bit_zero: assert property (p_reserved_bit_zero) else $error("reserved bit read nonzero"); // [RULE1]

    property p_level_read;
        (psel && !penable && !pwrite && paddr == gupc_pkg::OFS_CFG)
            |=> (prdata[18] == $past(level[0])) && (prdata[30] == $past(level[4]));
    endproperty
    a_level_read: assert property (p_level_read) else $error("level bit not reflected"); // [RULE2]

    property p_out_drive;
        (cfg_wr && !sel_wr && s.sel[14:12] == gupc_pkg::FSEL_OUTPUT)
            |=> pin_oe[4] && (pin_out[4] == $past(pwdata[29]));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("output pin not driven from drive bit"); // [RULE3]

    property p_flag_set;
        change[0] |=> s.flag[0] ##1 (s.flag[0] || $past(cfg_wr && pwdata[16]));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change flag not set"); // [RULE4]

    property p_irq_set;
        (change[2] && s.irq_en[2]) |=> s.irq_stat[2] && irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("enabled change did not raise interrupt"); // [RULE5]

    property p_irq_masked;
        (!s.irq_en[1] && !s.irq_stat[1] && !en_wr) |=> !s.irq_stat[1];
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked source raised interrupt"); // [RULE5]

    property p_w1c;
        (cfg_wr && pwdata[19] && !change[1]) |=> !s.flag[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by write one"); // [RULE6]

    property p_input_mode;
        (s.sel[8:6] == gupc_pkg::FSEL_INPUT && !sel_wr) |=> !pin_oe[2];
    endproperty
    a_input_mode: assert property (p_input_mode) else $error("input-selected pin driven"); // [RULE7]

    property p_w0_keep;
        (cfg_wr && !pwdata[22] && s.flag[2]) |=> s.flag[2];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("writing zero cleared a flag"); // [RULE8]

    property p_level_rest;
        (psel && !penable && !pwrite && paddr == gupc_pkg::OFS_CFG)
            |=> (prdata[21] == $past(level[1])) && (prdata[24] == $past(level[2]))
                && (prdata[27] == $past(level[3]));
    endproperty
    a_level_rest: assert property (p_level_rest) else $error("middle level bits not reflected"); // [RULE2]

    property p_drive_store;
        cfg_wr |=> (s.drive[0] == $past(bus.wdata[17])) && (s.drive[4] == $past(bus.wdata[29]));
    endproperty
    a_drive_store: assert property (p_drive_store) else $error("drive bit not stored"); // [RULE3]

    // a flag may only rise in the cycle after its pin changed, so a clear holds
    property p_flag_no_spurious;
        1'b1 |=> (s.flag & ~$past(s.flag) & ~$past(change)) == 5'h00;
    endproperty
    a_flag_no_spurious: assert property (p_flag_no_spurious) else $error("flag rose without change"); // [RULE6]

    property p_change_flag;
        1'b1 |=> ($past(change) & ~s.flag) == 5'h00;
    endproperty
    a_change_flag: assert property (p_change_flag) else $error("change did not set its flag"); // [RULE4]

    property p_irq_no_spurious;
        1'b1 |=> (s.irq_stat & ~$past(s.irq_stat) & ~($past(change) & $past(s.irq_en))) == 5'h00;
    endproperty
    a_irq_no_spurious: assert property (p_irq_no_spurious) else $error("interrupt status rose unasked"); // [RULE5]

    property p_irq_clear;
        (clr_wr && bus.wdata[3] && !change[3]) |=> !s.irq_stat[3];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt status not cleared"); // [RULE5]

    property p_en_store;
        en_wr |=> s.irq_en == $past(bus.wdata[4:0]);
    endproperty
    a_en_store: assert property (p_en_store) else $error("interrupt enable not stored"); // [RULE5]

    property p_sel_store;
        sel_wr |=> s.sel == $past(bus.wdata[30:16]);
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("function select not stored"); // [RULE7]

    property p_output_mode;
        (s.sel[2:0] == gupc_pkg::FSEL_OUTPUT && !sel_wr && !cfg_wr)
            |=> pin_oe[0] && (pin_out[0] == $past(s.drive[0]));
    endproperty
    a_output_mode: assert property (p_output_mode) else $error("output pin lost its drive bit"); // [RULE7]

    // codes between input and output hand the pin to the internal function
    property p_func_mode;
        (s.sel[5:3] != gupc_pkg::FSEL_INPUT && s.sel[5:3] != gupc_pkg::FSEL_OUTPUT && !sel_wr)
            |=> (pin_out[1] == $past(func_out[1])) && (pin_oe[1] == $past(func_oe[1]));
    endproperty
    a_func_mode: assert property (p_func_mode) else $error("internal function not routed"); // [RULE7]
endmodule
`default_nettype wire

// ### sim/gupc_tb.sv
// self-checking testbench for the upper pin configuration block.
// assumes gupc_top with a zero-wait apb slave; pins are driven as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {string name; logic [32:0] v; logic [32:0] m;} gupc_note_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        peek = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pin_in = 5'h00;
    logic [4:0]  func_out = 5'h00;
    logic [4:0]  func_oe = 5'h00;
    logic [4:0]  pin_out;
    logic [4:0]  pin_oe;
    logic [4:0]  sys_irq;
    logic        irq;
    logic [4:0]  drv, lvl, flg, en, fo, fe;
    logic [2:0]  sc;
    int          n_fail = 0;
    int          n_checks = 0;
    gupc_note_s  notes[$];

    gupc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out), .func_oe(func_oe),
        .system_pin_change_irq(sys_irq), .irq(irq));

    always #2 pclk = ~pclk;

    function automatic logic [31:0] spread(logic [4:0] v, int lsb);
        spread = 32'h0000_0000;
        for (int i = 0; i < 5; i++) begin
            spread[lsb + 3 * i] = v[i];
        end
    endfunction

    function automatic logic [31:0] cfg_word();
        return spread(lvl, gupc_pkg::LEVEL_LSB) | spread(drv, gupc_pkg::DRIVE_LSB) | spread(flg, gupc_pkg::FLAG_LSB);
    endfunction

    // request is held until pready is seen high; release is left to the caller
    // so that back-to-back transfers need no idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] v, input logic [32:0] m, input string nm);
        notes.push_back('{nm, v, m});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
        apb(1'b1, a, d, {err, 32'h0000_0000}, {1'b1, 32'h0000_0000}, "pslverr");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err = 1'b0);
        apb(1'b0, a, 32'h0000_0000, {err, x}, {33{1'b1}}, "prdata");
    endtask

    task automatic settle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    // v and m are {irq, system_pin_change_irq, pin_oe, pin_out}
    task automatic port_chk(input logic [15:0] v, input logic [15:0] m);
        notes.push_back('{"pins", {17'h00000, v}, {17'h00000, m}});
        peek <= 1'b1;
        @(posedge pclk);
        peek <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        gupc_note_s  n;
        logic [32:0] seen;
        if ((peek || (psel && penable && pready === 1'b1)) && notes.size() > 0) begin
            seen = peek ? {17'h00000, irq, sys_irq, pin_oe, pin_out} : {pslverr, prdata};
            n = notes.pop_front();
            n_checks++;
            if (((seen ^ n.v) & n.m) !== 33'h0_0000_0000) begin
                $display("CHECK FAILED %s expected %h seen %h", n.name, n.v & n.m, seen & n.m);
                n_fail++;
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(86270));
        drv = 5'h00;
        lvl = 5'h00;
        flg = 5'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(gupc_pkg::OFS_CFG, 32'h0000_0000);
        rd(gupc_pkg::OFS_SELECT, 32'h0000_0000);
        rd(gupc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        settle(1);
        port_chk(16'h0000, 16'hFFFF);
        wr(gupc_pkg::OFS_CFG, 32'hFFFF_FFFF);
        drv = 5'h1F;
        rd(gupc_pkg::OFS_CFG, cfg_word());
        for (int c = 0; c < 8; c++) begin
            sc = c[2:0];
            fo = 5'($urandom);
            fe = 5'($urandom);
            func_out <= fo;
            func_oe <= fe;
            drv = 5'($urandom);
            wr(gupc_pkg::OFS_SELECT, {1'b0, {5{sc}}, 16'h0000});
            wr(gupc_pkg::OFS_CFG, spread(drv, gupc_pkg::DRIVE_LSB));
            rd(gupc_pkg::OFS_SELECT, {1'b0, {5{sc}}, 16'h0000});
            settle(1);
            if (sc == gupc_pkg::FSEL_INPUT) port_chk(16'h0000, 16'hFFE0);
            else if (sc == gupc_pkg::FSEL_OUTPUT) port_chk({6'h00, 5'h1F, drv}, 16'hFFFF);
            else port_chk({6'h00, fe, fo}, 16'hFFFF);
        end
        wr(gupc_pkg::OFS_SELECT, 32'h0000_0000);
        en = 5'($urandom) | 5'h01 & 5'h1D;
        en[1] = 1'b0;
        wr(gupc_pkg::OFS_IRQ_EN, {27'h0000000, en});
        rd(gupc_pkg::OFS_IRQ_EN, {27'h0000000, en});
        settle(1);
        lvl = 5'($urandom) | 5'h03;
        pin_in <= lvl;
        flg = lvl;
        settle(6);
        rd(gupc_pkg::OFS_CFG, cfg_word());
        settle(1);
        port_chk({|(flg & en), flg & en, 10'h000}, 16'hFFE0);
        wr(gupc_pkg::OFS_CFG, spread(drv, gupc_pkg::DRIVE_LSB));
        rd(gupc_pkg::OFS_CFG, cfg_word());
        wr(gupc_pkg::OFS_CFG, spread(drv, gupc_pkg::DRIVE_LSB) | spread(5'h01, gupc_pkg::FLAG_LSB));
        flg[0] = 1'b0;
        rd(gupc_pkg::OFS_CFG, cfg_word());
        settle(10);
        rd(gupc_pkg::OFS_CFG, cfg_word());
        rd(gupc_pkg::OFS_IRQ_STAT, {27'h0000000, lvl & en});
        wr(gupc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        wr(gupc_pkg::OFS_IRQ_CLR, 32'h0000_001F);
        rd(gupc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        rd(gupc_pkg::OFS_IRQ_CLR, 32'h0000_0000);
        settle(1);
        port_chk(16'h0000, 16'hFFE0);
        lvl[0] = 1'b0;
        pin_in <= lvl;
        flg[0] = 1'b1;
        settle(6);
        rd(gupc_pkg::OFS_CFG, cfg_word());
        settle(1);
        port_chk({1'b1, 5'h01, 10'h000}, 16'hFFE0);
        rd(12'h100, 32'h0000_0000, 1'b1);
        wr(12'h100, 32'hFFFF_FFFF, 1'b1);
        rd(gupc_pkg::OFS_CFG, cfg_word());
        settle(2);
        end_of_test();
    end
endmodule
`default_nettype wire
